// File: pkg/csie_defs.svh
// offsets, field positions, reset values and vector constants
`ifndef CSIE_DEFS_SVH
`define CSIE_DEFS_SVH

// apb register byte addresses
`define CSIE_OFF_STATUS   12'h000
`define CSIE_OFF_PEND     12'h004
`define CSIE_OFF_ENABLE   12'h008
`define CSIE_OFF_EVSTAT   12'h00C
`define CSIE_OFF_EVMASK   12'h010

// status register fields
`define CSIE_BIT_CARRY    3'd0
`define CSIE_BIT_NIBBLE   3'd1
`define CSIE_BIT_ZERO     3'd2
`define CSIE_BIT_SLEEP    3'd3
`define CSIE_BIT_WDT      3'd4
`define CSIE_BIT_PAGE     3'd5
`define CSIE_STATUS_RST   8'h00
`define CSIE_STATUS_WMASK 8'hE7

// event status fields
`define CSIE_EV_WDT       2'd0
`define CSIE_EV_SLEEP     2'd1
`define CSIE_EV_ACCEPT    2'd2
`define CSIE_EV_RST       3'h0

// interrupt entry
`define CSIE_RESET_VEC    12'h000
`define CSIE_IRQ_VEC      12'h001
`define CSIE_NUM_SRC      8

`endif

// File: pkg/csie_pkg.sv
// types shared by the status and interrupt entry block
package csie_pkg;
  typedef logic [7:0]  csie_byte_t;
  typedef logic [11:0] csie_addr_t;
  typedef logic [31:0] csie_word_t;
  typedef enum logic [1:0] {
    CSIE_OP_LOGIC,
    CSIE_OP_ADD,
    CSIE_OP_SUB
  } csie_op_e;
  typedef enum logic [1:0] {
    CSIE_LK_FREE,
    CSIE_LK_SERVING,
    CSIE_LK_RETURNING
  } csie_lock_e;
endpackage : csie_pkg

// File: pkg/csie_flag_if.sv
// carrier between the status block and its flag evaluator
`timescale 1ns/10ps
`default_nettype none
interface csie_flag_if;
  import csie_pkg::*;
  csie_byte_t opA;
  csie_byte_t opB;
  csie_byte_t result;
  csie_op_e   op;
  logic       carry;
  logic       nibble;
  logic       zero;
  modport core (output opA, opB, result, op, input carry, nibble, zero);
  modport eval (input opA, opB, result, op, output carry, nibble, zero);
endinterface : csie_flag_if
`default_nettype wire

// File: src/csie_alu_flags.sv
// carry, nibble carry and zero evaluation for one alu operation
`timescale 1ns/10ps
`default_nettype none
module csie_alu_flags (
  // operands and flags
  csie_flag_if.eval fl
);
  import csie_pkg::*;

  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] opBEff;
  logic       cin;

  // subtract is add of complement plus one, so carry reads as no-borrow
  always_comb begin
    opBEff = (fl.op == CSIE_OP_SUB) ? ~fl.opB : fl.opB;
    cin    = (fl.op == CSIE_OP_SUB);
    full   = {1'b0, fl.opA} + {1'b0, opBEff} + {8'h00, cin};
    low    = {1'b0, fl.opA[3:0]} + {1'b0, opBEff[3:0]} + {4'h0, cin};
  end

  assign fl.nibble = low[4];
  assign fl.carry  = full[8];
  assign fl.zero   = (fl.result == 8'h00);
endmodule : csie_alu_flags
`default_nettype wire

// File: src/csie_status_irq.sv
// cpu status register and single-vector interrupt entry
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "csie_defs.svh"
module csie_status_irq (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // pin or watchdog reset request, asynchronous level
  input  wire logic                softRstReq,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire csie_pkg::csie_word_t pwdata,
  output var  csie_pkg::csie_word_t prdata,
  output logic                     pready,
  output logic                     pslverr,
  // instruction sequencer
  input  wire logic                instrEnd,
  input  wire csie_pkg::csie_op_e  aluOp,
  input  wire csie_pkg::csie_byte_t aluA,
  input  wire csie_pkg::csie_byte_t aluB,
  input  wire csie_pkg::csie_byte_t aluResult,
  input  wire logic                affectC,
  input  wire logic                affectNib,
  input  wire logic                affectZ,
  input  wire logic                statusWr,
  input  wire csie_pkg::csie_byte_t statusWrData,
  input  wire logic                watchdogKickInstr,
  input  wire logic                sleepInstr,
  input  wire logic                interruptReturnInstr,
  input  wire logic                wdtTimeout,
  // peripheral events
  input  wire logic [7:0]          srcEvent,
  // core controls
  output var  csie_pkg::csie_byte_t statusOut,
  output logic                     injectCall,
  output var  csie_pkg::csie_addr_t callTarget,
  output logic                     pushReturn,
  output logic                     serviceLock,
  output logic                     irqOut
);
  import csie_pkg::*;
  //------------------------------------------------------------------
  // reset request synchroniser
  //------------------------------------------------------------------
  logic softMeta_ff;
  logic softSync_ff;
  logic softPrev_ff;
  logic softRst;
  // two stages before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      softMeta_ff <= 1'b0;
      softSync_ff <= 1'b0;
      softPrev_ff <= 1'b0;
    end else begin
      softMeta_ff <= softRstReq;
      softSync_ff <= softMeta_ff;
      softPrev_ff <= softSync_ff;
    end
  end
  // held level acts as a reset for control registers
  assign softRst = softSync_ff | softPrev_ff;

  //------------------------------------------------------------------
  // flag evaluator
  //------------------------------------------------------------------
  csie_flag_if flagBus ();
  assign flagBus.opA    = aluA;
  assign flagBus.opB    = aluB;
  assign flagBus.result = aluResult;
  assign flagBus.op     = aluOp;
  csie_alu_flags u_flags (
    .fl (flagBus.eval)
  );
  //------------------------------------------------------------------
  // apb decode
  //------------------------------------------------------------------
  logic apbWr;
  logic apbRd;
  logic hitStatus;
  logic hitPend;
  logic hitEnable;
  logic hitEvStat;
  logic hitEvMask;
  logic hitAny;
  // zero wait state slave
  assign pready = 1'b1;
  assign apbWr  = psel & penable & pwrite;
  assign apbRd  = psel & penable & ~pwrite;
  // address decode
  always_comb begin
    hitStatus = 1'b0;
    hitPend   = 1'b0;
    hitEnable = 1'b0;
    hitEvStat = 1'b0;
    hitEvMask = 1'b0;
    if (paddr == `CSIE_OFF_STATUS) begin
      hitStatus = 1'b1;
    end else if (paddr == `CSIE_OFF_PEND) begin
      hitPend = 1'b1;
    end else if (paddr == `CSIE_OFF_ENABLE) begin
      hitEnable = 1'b1;
    end else if (paddr == `CSIE_OFF_EVSTAT) begin
      hitEvStat = 1'b1;
    end else if (paddr == `CSIE_OFF_EVMASK) begin
      hitEvMask = 1'b1;
    end
  end
  assign hitAny  = hitStatus | hitPend | hitEnable | hitEvStat | hitEvMask;
  assign pslverr = psel & penable & ~hitAny;

  //------------------------------------------------------------------
  // status register
  //------------------------------------------------------------------
  csie_byte_t status_ff;
  csie_byte_t nxt_status;
  csie_byte_t wrVal;
  logic       wrEn;
  logic [7:0] keepMask;
  // software write from the core or the bus; core wins on a tie
  always_comb begin
    wrEn  = (instrEnd & statusWr) | (apbWr & hitStatus);
    wrVal = (instrEnd & statusWr) ? statusWrData : pwdata[7:0];
  end
  // next status value
  always_comb begin
    nxt_status = status_ff;
    keepMask   = `CSIE_STATUS_WMASK;
    if (instrEnd) begin
      // flags the instruction updates are not writable
      if (affectC) keepMask[`CSIE_BIT_CARRY] = 1'b0;
      if (affectNib) keepMask[`CSIE_BIT_NIBBLE] = 1'b0;
      if (affectZ) keepMask[`CSIE_BIT_ZERO] = 1'b0;
    end
    if (wrEn) begin
      nxt_status = (status_ff & ~keepMask) | (wrVal & keepMask);
    end
    if (instrEnd) begin
      if (affectC) nxt_status[`CSIE_BIT_CARRY] = flagBus.carry;
      if (affectNib) nxt_status[`CSIE_BIT_NIBBLE] = flagBus.nibble;
      if (affectZ) nxt_status[`CSIE_BIT_ZERO] = flagBus.zero;
    end
    // watchdog flag clears on kick or sleep
    if (instrEnd & (watchdogKickInstr | sleepInstr)) begin
      nxt_status[`CSIE_BIT_WDT] = 1'b0;
    end
    // sleep flag clears on kick, sets on sleep
    if (instrEnd & watchdogKickInstr) begin
      nxt_status[`CSIE_BIT_SLEEP] = 1'b0;
    end else if (instrEnd & sleepInstr) begin
      nxt_status[`CSIE_BIT_SLEEP] = 1'b1;
    end
    if (wdtTimeout) begin
      nxt_status[`CSIE_BIT_WDT] = 1'b1;
    end
    // soft reset clears all but the reset-cause flags
    if (softRst) begin
      nxt_status = (nxt_status & ~`CSIE_STATUS_WMASK)
                   | (`CSIE_STATUS_RST & `CSIE_STATUS_WMASK);
    end
  end

  // power-on reset clears both cause flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= `CSIE_STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end
  assign statusOut = status_ff;

  //------------------------------------------------------------------
  // pending flags and enables
  //------------------------------------------------------------------
  logic [7:0] pend_ff;
  logic [7:0] enable_ff;
  logic [7:0] request;
  logic       accept;
  // events set pending whatever the enable; set beats clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_ff <= 8'h00;
    end else if (softRst) begin
      pend_ff <= 8'h00;
    end else if (apbWr & hitPend) begin
      pend_ff <= (pend_ff & ~pwdata[7:0]) | srcEvent;
    end else begin
      pend_ff <= pend_ff | srcEvent;
    end
  end

  // per-source enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_ff <= 8'h00;
    end else if (softRst) begin
      enable_ff <= 8'h00;
    end else if (apbWr & hitEnable) begin
      enable_ff <= pwdata[7:0];
    end
  end

  // level request from every armed pending flag
  assign request = pend_ff & enable_ff;

  //------------------------------------------------------------------
  // service lock
  //------------------------------------------------------------------
  csie_lock_e lock_ff;
  // any armed source shares the one entry
  // taken only at instruction end, one shared vector
  assign accept = instrEnd & (lock_ff == CSIE_LK_FREE) & (|request)
                  & ~softRst;

  // lock drops at the end of the instruction after return
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_ff <= CSIE_LK_FREE;
    end else if (softRst) begin
      lock_ff <= CSIE_LK_FREE;
    end else begin
      case (lock_ff)
        CSIE_LK_FREE: begin
          if (accept) lock_ff <= CSIE_LK_SERVING;
        end
        CSIE_LK_SERVING: begin
          if (instrEnd & interruptReturnInstr) begin
            lock_ff <= CSIE_LK_RETURNING;
          end
        end
        CSIE_LK_RETURNING: begin
          if (instrEnd) lock_ff <= CSIE_LK_FREE;
        end
        default: lock_ff <= CSIE_LK_FREE;
      endcase
    end
  end
  assign serviceLock = (lock_ff != CSIE_LK_FREE);

  //------------------------------------------------------------------
  // call injection
  //------------------------------------------------------------------
  logic       inject_ff;
  csie_addr_t target_ff;
  // one-cycle call request toward the sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inject_ff <= 1'b0;
      target_ff <= `CSIE_RESET_VEC;
    end else begin
      inject_ff <= accept;
      if (accept) target_ff <= `CSIE_IRQ_VEC;
    end
  end
  assign injectCall = inject_ff;
  assign callTarget = target_ff;
  // entry pushes the return address like a call
  assign pushReturn = inject_ff;

  //------------------------------------------------------------------
  // block event status and mask
  //------------------------------------------------------------------
  logic [2:0] evStat_ff;
  logic [2:0] evMask_ff;
  logic [2:0] evSet;
  assign evSet = {accept, instrEnd & sleepInstr, wdtTimeout};
  // sticky bits cleared by a read; a new event wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evStat_ff <= `CSIE_EV_RST;
    end else if (apbRd & hitEvStat) begin
      evStat_ff <= evSet;
    end else begin
      evStat_ff <= evStat_ff | evSet;
    end
  end

  // event mask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evMask_ff <= `CSIE_EV_RST;
    end else if (apbWr & hitEvMask) begin
      evMask_ff <= pwdata[2:0];
    end
  end
  assign irqOut = |(evStat_ff & evMask_ff);

  //------------------------------------------------------------------
  // read mux
  //------------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (hitStatus) begin
      prdata[7:0] = status_ff;
    end else if (hitPend) begin
      prdata[7:0] = pend_ff;
    end else if (hitEnable) begin
      prdata[7:0] = enable_ff;
    end else if (hitEvStat) begin
      prdata[2:0] = evStat_ff;
    end else if (hitEvMask) begin
      prdata[2:0] = evMask_ff;
    end
  end
endmodule : csie_status_irq
`default_nettype wire

// File: verification/csie_seq_model.sv
// instruction sequencer model that paces instruction ends
`timescale 1ns/10ps
`default_nettype none
module csie_seq_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // pacing: low ends every second cycle, high every fourth
  input  wire logic slow,
  // instruction boundary
  output logic      instrEnd
);
  logic [1:0] phase_ff;
  // ---------------------------------------------------------------
  // instruction pacing
  // ---------------------------------------------------------------
  // one-cycle end pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= 2'h0;
      instrEnd <= 1'b0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      instrEnd <= slow ? (phase_ff == 2'h3) : phase_ff[0];
    end
  end
endmodule : csie_seq_model
`default_nettype wire

// File: verification/csie_status_irq_monitor.sv
// port assertions for the status and interrupt entry block
`timescale 1ns/10ps
`default_nettype none
module csie_status_irq_monitor (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 arst_n,
  // sequencer
  input wire logic                 instrEnd,
  input wire csie_pkg::csie_op_e   aluOp,
  input wire csie_pkg::csie_byte_t aluA,
  input wire csie_pkg::csie_byte_t aluB,
  input wire csie_pkg::csie_byte_t aluResult,
  input wire logic                 affectC,
  input wire logic                 affectNib,
  input wire logic                 affectZ,
  input wire logic                 watchdogKickInstr,
  input wire logic                 sleepInstr,
  input wire logic                 interruptReturnInstr,
  input wire logic                 wdtTimeout,
  // core controls
  input wire csie_pkg::csie_byte_t statusOut,
  input wire logic                 injectCall,
  input wire csie_pkg::csie_addr_t callTarget,
  input wire logic                 pushReturn,
  input wire logic                 serviceLock
);
  import csie_pkg::*;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic       expC;
  logic       expNib;
  // ---------------------------------------------------------------
  // expected carries, subtract gives no-borrow
  // ---------------------------------------------------------------
  always_comb begin
    sum9  = {1'b0, aluA} + {1'b0, aluB};
    sum5  = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]};
    expC  = (aluOp == CSIE_OP_SUB) ? (aluA >= aluB) : sum9[8];
    expNib = (aluOp == CSIE_OP_SUB) ? (aluA[3:0] >= aluB[3:0]) : sum5[4];
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence retDone;
    serviceLock && instrEnd && interruptReturnInstr;
  endsequence
  sequence nextEnd;
    first_match(##[0:8] instrEnd);
  endsequence
  a_call_boundary: assert property (injectCall |->
    $past(instrEnd) && !$past(serviceLock)) else $error("call off boundary");
  a_call_vector: assert property (injectCall |->
    callTarget == 12'h001) else $error("call target wrong");
  a_push_lock: assert property (injectCall |->
    pushReturn && serviceLock) else $error("call without push or lock");
  a_lock_release: assert property (retDone ##1 nextEnd
    |=> !serviceLock) else $error("lock not released");
  a_lock_hold: assert property (retDone |=> serviceLock)
    else $error("lock dropped at return");
  a_carry_flag: assert property (instrEnd && affectC &&
    aluOp != CSIE_OP_LOGIC |=> statusOut[0] == $past(expC))
    else $error("carry flag wrong");
  a_nibble_flag: assert property (instrEnd && affectNib &&
    aluOp != CSIE_OP_LOGIC |=> statusOut[1] == $past(expNib))
    else $error("nibble carry wrong");
  a_zero_flag: assert property (instrEnd && affectZ |=>
    statusOut[2] == ($past(aluResult) == 8'h00)) else $error("zero wrong");
  a_wdt_set: assert property (wdtTimeout |=> statusOut[4])
    else $error("timeout flag not set");
  a_sleep_set: assert property (instrEnd && sleepInstr &&
    !wdtTimeout |=> statusOut[4:3] == 2'b01) else $error("sleep flags");
  a_kick_clear: assert property (instrEnd &&
    watchdogKickInstr && !wdtTimeout |=> statusOut[4:3] == 2'b00)
    else $error("kick flags");
endmodule : csie_status_irq_monitor
bind csie_status_irq csie_status_irq_monitor i_mon (.clk, .arst_n,
  .instrEnd, .aluOp, .aluA, .aluB, .aluResult, .affectC, .affectNib,
  .affectZ, .watchdogKickInstr, .sleepInstr, .interruptReturnInstr,
  .wdtTimeout, .statusOut, .injectCall, .callTarget, .pushReturn,
  .serviceLock);
`default_nettype wire

// File: verification/csie_status_irq_tb.sv
// self-checking bench for the status and interrupt entry block
`timescale 1ns/10ps
`default_nettype none
`include "csie_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module csie_status_irq_tb;
  import csie_pkg::*;
  logic       clk, arst_n, softRstReq, psel, penable, pwrite, pready;
  logic       pslverr, instrEnd, affectC, affectNib, affectZ, statusWr;
  logic       watchdogKickInstr, sleepInstr, interruptReturnInstr;
  logic       wdtTimeout, injectCall, pushReturn, serviceLock, irqOut;
  logic       slow, irqSeen, c, h;
  logic [11:0] paddr;
  logic [7:0] srcEvent;
  csie_word_t pwdata, prdata, q[$];
  csie_op_e   aluOp;
  csie_byte_t aluA, aluB, aluResult, statusWrData, statusOut, a, b, d, r;
  csie_addr_t callTarget;
  int         fail_count, num_checks, i, k;
  csie_status_irq i_csie_status_irq (.clk, .arst_n, .softRstReq, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instrEnd, .aluOp, .aluA, .aluB, .aluResult, .affectC, .affectNib,
    .affectZ, .statusWr, .statusWrData, .watchdogKickInstr, .sleepInstr,
    .interruptReturnInstr, .wdtTimeout, .srcEvent, .statusOut, .injectCall,
    .callTarget, .pushReturn, .serviceLock, .irqOut);
  csie_seq_model i_csie_seq_model (.clk, .arst_n, .slow, .instrEnd);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    if (q.size() != 0) begin
      fail_count++;
      $display("ERROR t=%0t got=none exp=%h", $time, q[0]);
    end
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic wait_high(ref logic s, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      if (s === 1'b1) break;
    end
    if (n == lim) begin
      fail_count++;
      end_of_test();
    end
  endtask : wait_high
  task automatic ex(input csie_word_t e);
    q.push_back(e);
  endtask : ex
  // apb transfer, request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] ad, csie_word_t dt);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    wait_high(pready, 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic rd(input logic [11:0] ad, input csie_word_t e);
    ex(e);
    xfer(1'b0, ad, 32'h0);
  endtask : rd
  // hold the instruction fields until the sequencer ends the instruction
  task automatic fire;
    wait_high(instrEnd, 20);
    {affectC, affectNib, affectZ, statusWr, watchdogKickInstr} <= 5'h00;
    {sleepInstr, interruptReturnInstr} <= 2'h0;
    @(posedge clk);
  endtask : fire
  task automatic wdt;
    wdtTimeout <= 1'b1;
    @(posedge clk);
    wdtTimeout <= 1'b0;
    @(posedge clk);
  endtask : wdt
  task automatic pop(input csie_word_t got);
    csie_word_t e;
    if (q.size() == 0) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=none", $time, got);
    end else begin
      e = q.pop_front();
      `CHK(got, e)
    end
  endtask : pop
  // ---------------------------------------------------------------
  // clock and result monitor
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (arst_n === 1'b1 && psel && penable && pready)
      `CHK(pslverr, paddr > `CSIE_OFF_EVMASK)
    if (arst_n === 1'b1 && psel && penable && pready && !pwrite) pop(prdata);
    if (arst_n === 1'b1 && injectCall === 1'b1) pop({20'h00000, callTarget});
    if (arst_n === 1'b1 && irqOut !== irqSeen) begin
      pop({31'h0, irqOut});
      irqSeen = irqOut;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {arst_n, softRstReq, psel, penable, pwrite, wdtTimeout, slow} = 7'h00;
    {affectC, affectNib, affectZ, statusWr, watchdogKickInstr} = 5'h00;
    {sleepInstr, interruptReturnInstr, irqSeen, paddr} = 15'h0000;
    {pwdata, aluA, aluB, aluResult, statusWrData, srcEvent} = 72'h0;
    aluOp = CSIE_OP_LOGIC;
    void'($urandom(21));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(`CSIE_OFF_STATUS, 32'h0);
    xfer(1'b1, `CSIE_OFF_STATUS, 32'hFF);
    rd(`CSIE_OFF_STATUS, 32'hE7);
    xfer(1'b1, 12'h014, 32'hFF);
    rd(12'h014, 32'h0);
    $display("test registers done");
    for (i = 0; i < 9; i++) begin
      a = $urandom;
      b = (i == 5) ? a : $urandom;
      d = $urandom;
      if (i == 4) {a, b} = 16'hFF01;
      r = (i % 3 == 1) ? a + b : (i % 3 == 2) ? a - b : a & b;
      c = (i % 3 == 1) ? ({1'b0, a} + {1'b0, b}) > 9'h0FF : a >= b;
      h = (i % 3 == 1) ? (a[3:0] + b[3:0]) > 5'h0F : a[3:0] >= b[3:0];
      if (i % 3 == 0) {h, c} = d[1:0];
      aluOp <= csie_op_e'(i % 3);
      {aluA, aluB, aluResult, statusWrData} <= {a, b, r, d};
      {affectC, affectNib, affectZ, statusWr} <= {{2{i % 3 != 0}}, 2'b11};
      fire();
      rd(`CSIE_OFF_STATUS, {24'h0, d[7:5], 2'b00, r == 8'h00, h, c});
    end
    $display("test flags done");
    xfer(1'b1, `CSIE_OFF_STATUS, 32'h0);
    wdt();
    rd(`CSIE_OFF_STATUS, 32'h10);
    sleepInstr <= 1'b1;
    fire();
    rd(`CSIE_OFF_STATUS, 32'h08);
    wdt();
    xfer(1'b1, `CSIE_OFF_STATUS, 32'hFF);
    rd(`CSIE_OFF_STATUS, 32'hFF);
    softRstReq <= 1'b1;
    repeat (4) @(posedge clk);
    softRstReq <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`CSIE_OFF_STATUS, 32'h18);
    watchdogKickInstr <= 1'b1;
    fire();
    rd(`CSIE_OFF_STATUS, 32'h00);
    rd(`CSIE_OFF_EVSTAT, 32'h3);
    ex(32'h1);
    xfer(1'b1, `CSIE_OFF_EVMASK, 32'h1);
    wdt();
    ex(32'h0);
    xfer(1'b1, `CSIE_OFF_EVMASK, 32'h0);
    ex(32'h1);
    xfer(1'b1, `CSIE_OFF_EVMASK, 32'h1);
    ex(32'h1);
    ex(32'h0);
    xfer(1'b0, `CSIE_OFF_EVSTAT, 32'h0);
    $display("test reset cause done");
    k = $urandom % 8;
    srcEvent <= 8'h01 << k;
    @(posedge clk);
    srcEvent <= 8'h00;
    @(posedge clk);
    rd(`CSIE_OFF_PEND, 32'h1 << k);
    fire();
    fire();
    rd(`CSIE_OFF_EVSTAT, 32'h0);
    slow <= 1'b1;
    ex(32'h001);
    xfer(1'b1, `CSIE_OFF_ENABLE, 32'h1 << k);
    wait_high(injectCall, 40);
    fire();
    fire();
    interruptReturnInstr <= 1'b1;
    fire();
    ex(32'h001);
    wait_high(injectCall, 40);
    xfer(1'b1, `CSIE_OFF_PEND, 32'h1 << k);
    interruptReturnInstr <= 1'b1;
    fire();
    fire();
    fire();
    rd(`CSIE_OFF_EVSTAT, 32'h4);
    fire();
    rd(`CSIE_OFF_EVSTAT, 32'h0);
    $display("test interrupt done");
    end_of_test();
  end
endmodule : csie_status_irq_tb
`default_nettype wire
